// file: rtl/prt_defines.vh
`ifndef PRT_DEFINES_VH
`define PRT_DEFINES_VH

// Base address of each timer's basic register group
`define PRT_T0_BASE 8'h60
`define PRT_T1_BASE 8'h65
`define PRT_T2_BASE 8'h6F
`define PRT_T3_BASE 8'h74

// Offsets inside a basic group; data and reload share the last two
`define PRT_OFS_CTL 8'h00
`define PRT_OFS_IER 8'h01
`define PRT_OFS_IIR 8'h02
`define PRT_OFS_DATA_L 8'h03
`define PRT_OFS_DATA_H 8'h04

// Capture groups: control, A low, A high, B low, B high
`define PRT_T1_CAP_BASE 8'h6A
`define PRT_T3_CAP_BASE 8'h7A
`define PRT_CAP_OFS_CTL 8'h00
`define PRT_CAP_OFS_A_L 8'h01
`define PRT_CAP_OFS_A_H 8'h02
`define PRT_CAP_OFS_B_L 8'h03
`define PRT_CAP_OFS_B_H 8'h04

// Timer 3 compare registers (visible while multi-PWM is off; PWM_CTL1 is always visible)
`define PRT_PWM_CTL1 8'h79
`define PRT_OC_CTL1 8'h7F
`define PRT_OC_CTL2 8'h80
`define PRT_OC_VAL_BASE 8'h81
`define PRT_OC_VAL_LAST 8'h88

// Timer 3 PWM overlay (visible while multi-PWM is on)
`define PRT_PWM_CTL2 8'h7A
`define PRT_PWM_CTL3 8'h7B
`define PRT_PWM_EDGE_BASE 8'h7C
`define PRT_PWM_EDGE_LAST 8'h8B

// Control register fields
`define PRT_CTL_EN 0
`define PRT_CTL_RLD 1
`define PRT_CTL_CONT 2
`define PRT_CTL_DIV_LO 3
`define PRT_CTL_SRC_LO 5
`define PRT_CTL_HALT 7
`define PRT_CTL_RESET 8'h00

// Tick sources
`define PRT_SRC_PRESCALE 2'h0
`define PRT_SRC_RTC 2'h1
`define PRT_SRC_EV_FALL 2'h2
`define PRT_SRC_EV_RISE 2'h3

// Prescaler terminal counts for divide by 4, 16, 64, 256
`define PRT_PRE_LAST_4 8'h03
`define PRT_PRE_LAST_16 8'h0F
`define PRT_PRE_LAST_64 8'h3F
`define PRT_PRE_LAST_256 8'hFF

// Count value at which a tick ends the count
`define PRT_LAST_COUNT 16'h0001

// Interrupt cause bits
`define PRT_IRQ_EOC 0
`define PRT_IRQ_ICA 1
`define PRT_IRQ_ICB 2
`define PRT_IRQ_OC0 3

// Capture edge codes (bit 0 rising, bit 1 falling)
`define PRT_CAP_A_LO 0
`define PRT_CAP_B_LO 2

// Compare and PWM control fields
`define PRT_OC_EN 0
`define PRT_OC_MAST 1
`define PRT_OC_INIT_LO 4
`define PRT_OC_MODE_FORCE 2'h0
`define PRT_OC_MODE_SET 2'h1
`define PRT_OC_MODE_CLEAR 2'h2
`define PRT_OC_MODE_TOGGLE 2'h3
`define PRT_PWM_EN 0

`endif

// file: rtl/prt_core.v
`timescale 1ns/1ps
`include "prt_defines.vh"

module prt_core #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire sys_rst,
  input wire run,
  input wire [1:0] src_sel,
  input wire [1:0] div_sel,
  input wire continuous,
  input wire force_load,
  input wire [WIDTH-1:0] reload,
  input wire event_pin,
  input wire rtc_in,
  output reg [WIDTH-1:0] count,
  output wire tick,
  output wire eoc
);

  reg [2:0] ev_sync;
  reg [2:0] rtc_sync;
  reg [7:0] pre;
  reg [7:0] pre_last;
  reg src_tick;
  wire ev_rise;
  wire ev_fall;
  wire rtc_rise;

  // Pin and RTC samplers; stage 0 feeds only stage 1, edges come from stages 1 and 2
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ev_sync <= 3'h0;
      rtc_sync <= 3'h0;
    end else begin
      ev_sync <= {ev_sync[1:0], event_pin};
      rtc_sync <= {rtc_sync[1:0], rtc_in};
    end
  end

  // Edge seen after the second edge, counter moves on the third
  assign ev_rise = ev_sync[1] & ~ev_sync[2];
  assign ev_fall = ~ev_sync[1] & ev_sync[2];
  assign rtc_rise = rtc_sync[1] & ~rtc_sync[2];

  // Prescaler terminal count
  always @* begin
    case (div_sel)
      2'h0: pre_last = `PRT_PRE_LAST_4;
      2'h1: pre_last = `PRT_PRE_LAST_16;
      2'h2: pre_last = `PRT_PRE_LAST_64;
      default: pre_last = `PRT_PRE_LAST_256;
    endcase
  end

  // Prescaler runs only for the system clock source, restarts when stopped
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pre <= 8'h00;
    end else if (!run || src_sel != `PRT_SRC_PRESCALE) begin
      pre <= 8'h00;
    end else if (pre == pre_last) begin
      pre <= 8'h00;
    end else begin
      pre <= pre + 8'h01;
    end
  end

  // Tick source selection
  always @* begin
    case (src_sel)
      `PRT_SRC_PRESCALE: src_tick = (pre == pre_last);
      `PRT_SRC_RTC: src_tick = rtc_rise;
      `PRT_SRC_EV_FALL: src_tick = ev_fall;
      default: src_tick = ev_rise;
    endcase
  end

  assign tick = run & src_tick & ~force_load;
  assign eoc = tick & (count == `PRT_LAST_COUNT);

  // Down-counter; a forced reload beats a tick in the same cycle
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count <= {WIDTH{1'b0}};
    end else if (force_load) begin
      count <= reload;
    end else if (eoc) begin
      count <= continuous ? reload : {WIDTH{1'b0}};
    end else if (tick) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: rtl/prt_top.v
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "prt_defines.vh"

// How it works
// - Five byte registers per timer.
// - Count readback and reload share addresses.
// - Timer 1 has capture control plus two pairs.
// - Timer 3 PWM overlays capture and compare.
// - Timer 3 capture mirrors timer 1 capture.
// - Two compare controls, four compare value pairs.
// - Three PWM controls, rising and falling pairs.
// - Debug halt bit freezes count during break.
// - Source field picks prescaler, RTC, pin edge.
// - Divider field selects 4, 16, 64, 256.
// - Single pass clears enable at end-of-count.
// - Continuous mode reloads at end-of-count.
// - Writing force reload loads counter immediately.
// - Enable bit gates all counting.
// - Pin edges bypass prescaler, counted third edge.
// - Reading interrupt cause register clears it.
// - RTC source behaves like sampled event pin.
module prt_top #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire [3:0] event_pin,
  input wire rtc_in,
  input wire debug_break,
  input wire [1:0] capture_pin_a,
  input wire [1:0] capture_pin_b,
  output wire [3:0] compare_out,
  output wire [3:0] pwm_out,
  output wire irq
);

  wire [4*WIDTH-1:0] count_bus;
  wire [3:0] tick_bus;
  wire [3:0] eoc_bus;
  wire [31:0] ev_bus;
  wire [31:0] t_rd;
  wire [3:0] irq_bus;
  wire [3:0] cap_ev;
  wire [15:0] cap_rd;
  wire [3:0] oc_ev;
  wire [WIDTH-1:0] count3;
  wire mpwm;
  reg [7:0] ext_rd;
  reg [7:0] pwm_ctl1;
  reg [7:0] pwm_ctl2;
  reg [7:0] pwm_ctl3;
  reg [7:0] oc_ctl1;
  reg [7:0] oc_ctl2;
  reg [7:0] oc_val [0:7];
  reg [7:0] pwm_val [0:15];
  reg tick3_d;
  wire [7:0] oc_idx;
  wire [7:0] edge_idx;
  wire oc_range;
  wire edge_range;
  integer j;

  function [7:0] timer_base;
    input integer n;
    begin
      case (n)
        0: timer_base = `PRT_T0_BASE;
        1: timer_base = `PRT_T1_BASE;
        2: timer_base = `PRT_T2_BASE;
        default: timer_base = `PRT_T3_BASE;
      endcase
    end
  endfunction

  assign mpwm = pwm_ctl1[`PRT_PWM_EN];
  assign count3 = count_bus[3*WIDTH +: WIDTH];

  // Event sources per timer, by cause bit
  assign ev_bus[7:0] = {7'h00, eoc_bus[0]};
  assign ev_bus[15:8] = {5'h00, cap_ev[1:0], eoc_bus[1]};
  assign ev_bus[23:16] = {7'h00, eoc_bus[2]};
  assign ev_bus[31:24] = {1'b0, oc_ev, cap_ev[3:2], eoc_bus[3]};

  // Basic register set and counter, one copy per timer
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_tmr
      wire [7:0] base = timer_base(i);
      wire hit_ctl = (reg_addr == base + `PRT_OFS_CTL);
      wire hit_ier = (reg_addr == base + `PRT_OFS_IER);
      wire hit_iir = (reg_addr == base + `PRT_OFS_IIR);
      wire hit_lo = (reg_addr == base + `PRT_OFS_DATA_L);
      wire hit_hi = (reg_addr == base + `PRT_OFS_DATA_H);
      wire [WIDTH-1:0] count;
      wire force_load;
      wire run;
      reg [7:0] ctl;
      reg [7:0] ier;
      reg [7:0] iir;
      reg [7:0] rld_lo;
      reg [7:0] rld_hi;
      reg [7:0] rd;

      // Force reload acts on the write itself and is never stored
      assign force_load = reg_write & hit_ctl & reg_wdata[`PRT_CTL_RLD];
      // A break only freezes the count when the halt bit asks for it
      assign run = ctl[`PRT_CTL_EN] & ~(ctl[`PRT_CTL_HALT] & debug_break);

      // Control register; software write wins over the single-pass stop
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          ctl <= `PRT_CTL_RESET;
        end else if (reg_write && hit_ctl) begin
          ctl <= reg_wdata & ~(8'h01 << `PRT_CTL_RLD);
        end else if (eoc_bus[i] && !ctl[`PRT_CTL_CONT]) begin
          ctl[`PRT_CTL_EN] <= 1'b0;
        end
      end

      // Mask and write-only reload bytes
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          ier <= 8'h00;
          rld_lo <= 8'h00;
          rld_hi <= 8'h00;
        end else if (reg_write) begin
          if (hit_ier) begin
            ier <= reg_wdata;
          end
          if (hit_lo) begin
            rld_lo <= reg_wdata;
          end
          if (hit_hi) begin
            rld_hi <= reg_wdata;
          end
        end
      end

      // Sticky causes; a read clears them but a same-cycle event survives
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          iir <= 8'h00;
        end else begin
          iir <= ((reg_read && hit_iir) ? 8'h00 : iir) | ev_bus[i*8 +: 8];
        end
      end

      // Reads of the shared data address show the live count
      always @* begin
        rd = 8'h00;
        if (hit_ctl) begin
          rd = ctl;
        end else if (hit_ier) begin
          rd = ier;
        end else if (hit_iir) begin
          rd = iir;
        end else if (hit_lo) begin
          rd = count[7:0];
        end else if (hit_hi) begin
          rd = count[15:8];
        end
      end

      assign t_rd[i*8 +: 8] = rd;
      assign irq_bus[i] = |(iir & ier);
      assign count_bus[i*WIDTH +: WIDTH] = count;

      prt_core #(
        .WIDTH(WIDTH)
      ) u_core (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(run),
        .src_sel(ctl[`PRT_CTL_SRC_LO +: 2]),
        .div_sel(ctl[`PRT_CTL_DIV_LO +: 2]),
        .continuous(ctl[`PRT_CTL_CONT]),
        .force_load(force_load),
        .reload({rld_hi, rld_lo}),
        .event_pin(event_pin[i]),
        .rtc_in(rtc_in),
        .count(count),
        .tick(tick_bus[i]),
        .eoc(eoc_bus[i])
      );
    end
  endgenerate

  // Capture units: index 0 serves timer 1, index 1 serves timer 3
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_cap
      wire [7:0] cbase = (k == 0) ? `PRT_T1_CAP_BASE : `PRT_T3_CAP_BASE;
      wire [WIDTH-1:0] cnt = count_bus[(2*k+1)*WIDTH +: WIDTH];
      // Timer 3 capture registers vanish under the PWM overlay
      wire visible = (k == 0) | ~mpwm;
      wire hit_ctl = visible & (reg_addr == cbase + `PRT_CAP_OFS_CTL);
      wire hit_al = visible & (reg_addr == cbase + `PRT_CAP_OFS_A_L);
      wire hit_ah = visible & (reg_addr == cbase + `PRT_CAP_OFS_A_H);
      wire hit_bl = visible & (reg_addr == cbase + `PRT_CAP_OFS_B_L);
      wire hit_bh = visible & (reg_addr == cbase + `PRT_CAP_OFS_B_H);
      reg [2:0] sa;
      reg [2:0] sb;
      reg [7:0] cctl;
      reg [WIDTH-1:0] cap_a;
      reg [WIDTH-1:0] cap_b;
      reg hold_a;
      reg hold_b;
      reg [7:0] rd;
      wire edge_a = (cctl[`PRT_CAP_A_LO] & sa[1] & ~sa[2]) | (cctl[`PRT_CAP_A_LO+1] & ~sa[1] & sa[2]);
      wire edge_b = (cctl[`PRT_CAP_B_LO] & sb[1] & ~sb[2]) | (cctl[`PRT_CAP_B_LO+1] & ~sb[1] & sb[2]);
      // A pending low-byte read locks out captures so the pair cannot tear
      wire take_a = visible & edge_a & ~hold_a;
      wire take_b = visible & edge_b & ~hold_b;

      // Capture pin samplers; stage 0 feeds only stage 1
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          sa <= 3'h0;
          sb <= 3'h0;
        end else begin
          sa <= {sa[1:0], capture_pin_a[k]};
          sb <= {sb[1:0], capture_pin_b[k]};
        end
      end

      // Capture control, latched values and read locks
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          cctl <= 8'h00;
          cap_a <= {WIDTH{1'b0}};
          cap_b <= {WIDTH{1'b0}};
          hold_a <= 1'b0;
          hold_b <= 1'b0;
        end else begin
          if (reg_write && hit_ctl) begin
            cctl <= reg_wdata;
          end
          if (take_a) begin
            cap_a <= cnt;
          end
          if (take_b) begin
            cap_b <= cnt;
          end
          if (reg_read && hit_al) begin
            hold_a <= 1'b1;
          end else if (reg_read && hit_ah) begin
            hold_a <= 1'b0;
          end
          if (reg_read && hit_bl) begin
            hold_b <= 1'b1;
          end else if (reg_read && hit_bh) begin
            hold_b <= 1'b0;
          end
        end
      end

      // Capture registers read back; values are read-only
      always @* begin
        rd = 8'h00;
        if (hit_ctl) begin
          rd = cctl;
        end else if (hit_al) begin
          rd = cap_a[7:0];
        end else if (hit_ah) begin
          rd = cap_a[15:8];
        end else if (hit_bl) begin
          rd = cap_b[7:0];
        end else if (hit_bh) begin
          rd = cap_b[15:8];
        end
      end

      assign cap_rd[k*8 +: 8] = rd;
      assign cap_ev[2*k +: 2] = {take_b, take_a};
    end
  endgenerate

  assign oc_idx = reg_addr - `PRT_OC_VAL_BASE;
  assign edge_idx = reg_addr - `PRT_PWM_EDGE_BASE;
  assign oc_range = ~mpwm & (reg_addr >= `PRT_OC_VAL_BASE) & (reg_addr <= `PRT_OC_VAL_LAST);
  assign edge_range = mpwm & (reg_addr >= `PRT_PWM_EDGE_BASE) & (reg_addr <= `PRT_PWM_EDGE_LAST);

  // Timer 3 compare and PWM registers; PWM_CTL1 stays visible to leave the overlay
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_ctl1 <= 8'h00;
      pwm_ctl2 <= 8'h00;
      pwm_ctl3 <= 8'h00;
      oc_ctl1 <= 8'h00;
      oc_ctl2 <= 8'h00;
      for (j = 0; j < 8; j = j + 1) begin
        oc_val[j] <= 8'h00;
      end
      for (j = 0; j < 16; j = j + 1) begin
        pwm_val[j] <= 8'h00;
      end
    end else if (reg_write) begin
      if (reg_addr == `PRT_PWM_CTL1) begin
        pwm_ctl1 <= reg_wdata;
      end else if (mpwm && reg_addr == `PRT_PWM_CTL2) begin
        pwm_ctl2 <= reg_wdata;
      end else if (mpwm && reg_addr == `PRT_PWM_CTL3) begin
        pwm_ctl3 <= reg_wdata;
      end else if (edge_range) begin
        pwm_val[edge_idx[3:0]] <= reg_wdata;
      end else if (!mpwm && reg_addr == `PRT_OC_CTL1) begin
        oc_ctl1 <= reg_wdata;
      end else if (!mpwm && reg_addr == `PRT_OC_CTL2) begin
        oc_ctl2 <= reg_wdata;
      end else if (oc_range) begin
        oc_val[oc_idx[2:0]] <= reg_wdata;
      end
    end
  end

  // Read decode for the timer 3 extension space; unmapped reads give zero
  always @* begin
    ext_rd = 8'h00;
    if (reg_addr == `PRT_PWM_CTL1) begin
      ext_rd = pwm_ctl1;
    end else if (mpwm && reg_addr == `PRT_PWM_CTL2) begin
      ext_rd = pwm_ctl2;
    end else if (mpwm && reg_addr == `PRT_PWM_CTL3) begin
      ext_rd = pwm_ctl3;
    end else if (edge_range) begin
      ext_rd = pwm_val[edge_idx[3:0]];
    end else if (!mpwm && reg_addr == `PRT_OC_CTL1) begin
      ext_rd = oc_ctl1;
    end else if (!mpwm && reg_addr == `PRT_OC_CTL2) begin
      ext_rd = oc_ctl2;
    end else if (oc_range) begin
      ext_rd = oc_val[oc_idx[2:0]];
    end
  end

  // Compares look at the count one cycle after it moves
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick3_d <= 1'b0;
    end else begin
      tick3_d <= tick_bus[3];
    end
  end

  // Compare and PWM outputs, one per channel; master mode copies channel 0
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_out
      wire src0 = oc_ctl1[`PRT_OC_MAST];
      wire [1:0] mode = src0 ? oc_ctl2[1:0] : oc_ctl2[2*c +: 2];
      wire [15:0] cval = src0 ? {oc_val[1], oc_val[0]} : {oc_val[2*c+1], oc_val[2*c]};
      wire hit = ~mpwm & oc_ctl1[`PRT_OC_EN] & tick3_d & (count3 == cval);
      wire [15:0] rise = {pwm_val[4*c+1], pwm_val[4*c]};
      wire [15:0] fall = {pwm_val[4*c+3], pwm_val[4*c+2]};
      reg oc_q;
      reg pwm_q;

      // Forced level holds until the mode changes, then waits for a match
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          oc_q <= 1'b0;
        end else if (mode == `PRT_OC_MODE_FORCE) begin
          oc_q <= oc_ctl1[`PRT_OC_INIT_LO + c];
        end else if (hit) begin
          case (mode)
            `PRT_OC_MODE_SET: oc_q <= 1'b1;
            `PRT_OC_MODE_CLEAR: oc_q <= 1'b0;
            `PRT_OC_MODE_TOGGLE: oc_q <= ~oc_q;
            default: oc_q <= oc_q;
          endcase
        end
      end

      // PWM goes high at its rising count and low at its falling count
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          pwm_q <= 1'b0;
        end else if (!mpwm) begin
          pwm_q <= 1'b0;
        end else if (tick3_d && count3 == rise) begin
          pwm_q <= 1'b1;
        end else if (tick3_d && count3 == fall) begin
          pwm_q <= 1'b0;
        end
      end

      assign compare_out[c] = oc_q;
      assign pwm_out[c] = pwm_q;
      assign oc_ev[c] = hit;
    end
  endgenerate

  // Read data stand only in the cycle after the strobe
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= t_rd[7:0] | t_rd[15:8] | t_rd[23:16] | t_rd[31:24] | cap_rd[7:0] | cap_rd[15:8] | ext_rd;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign irq = |irq_bus;

endmodule

// file: rtl/prt_top_end.v
`timescale 1ns/1ps

// file: bench/prt_top_assertions.sv
`timescale 1ns/1ps
module prt_top_checker #(
  parameter WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] event_pin,
  input wire logic rtc_in,
  input wire logic debug_break,
  input wire logic [1:0] capture_pin_a,
  input wire logic [1:0] capture_pin_b,
  input wire logic [3:0] compare_out,
  input wire logic [3:0] pwm_out,
  input wire logic irq
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Bus steps that the multi-step properties are built from
  sequence s_wr(a);
    reg_write && reg_addr == a;
  endsequence
  sequence s_rd(a);
    reg_read && reg_addr == a;
  endsequence
  sequence s_idle_ctl_wr;
    reg_write && reg_addr == 8'h60 && !reg_wdata[0];
  endsequence
  sequence s_force_after_reload;
    s_wr(8'h63) ##2 (s_wr(8'h60) ##0 reg_wdata == 8'h02);
  endsequence

  property p_idle_zero;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero outside read answer");
  property p_unmapped;
    reg_read && (reg_addr < 8'h60 || reg_addr > 8'h8B) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
  property p_force_reads_zero;
    reg_read && (reg_addr == 8'h60 || reg_addr == 8'h65 || reg_addr == 8'h6F || reg_addr == 8'h74)
      |=> !reg_rdata[1];
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force reload bit read back");
  property p_cause_unused;
    reg_read && (reg_addr == 8'h62 || reg_addr == 8'h67 || reg_addr == 8'h71 || reg_addr == 8'h76)
      |=> !reg_rdata[7];
  endproperty
  a_cause_unused: assert property (p_cause_unused) else $error("unused cause bit set");
  property p_mask_back;
    s_wr(8'h61) ##1 s_rd(8'h61) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_mask_back: assert property (p_mask_back) else $error("mask readback differs");
  property p_ctl_back;
    s_idle_ctl_wr ##1 s_rd(8'h60) |=> reg_rdata == ($past(reg_wdata, 2) & 8'hFD);
  endproperty
  a_ctl_back: assert property (p_ctl_back) else $error("control readback differs");
  property p_force_load;
    s_force_after_reload ##1 s_rd(8'h63) |=> reg_rdata == $past(reg_wdata, 4);
  endproperty
  a_force_load: assert property (p_force_load) else $error("force reload did not load count");
  property p_reset_quiet;
    $fell(sys_rst) |-> !irq && pwm_out == 4'h0 && compare_out == 4'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule

bind prt_top prt_top_checker #(.WIDTH(WIDTH)) u_chk (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .event_pin(event_pin), .rtc_in(rtc_in), .debug_break(debug_break), .capture_pin_a(capture_pin_a),
  .capture_pin_b(capture_pin_b), .compare_out(compare_out), .pwm_out(pwm_out), .irq(irq));

// file: bench/prt_top_tb_top.sv
`timescale 1ns/1ps
module prt_top_tb_top;
  localparam logic [7:0] TBASE [4] = '{8'h60, 8'h65, 8'h6F, 8'h74};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [3:0] event_pin = 4'h0;
  logic rtc_in = 1'b0;
  logic debug_break = 1'b0;
  logic [1:0] capture_pin_a = 2'h0;
  logic [1:0] capture_pin_b = 2'h0;
  wire [7:0] reg_rdata;
  wire [3:0] compare_out;
  wire [3:0] pwm_out;
  wire irq;
  int n_fail = 0;
  int checks = 0;

  // 125 MHz system clock
  always #4 clock = ~clock;

  prt_top #(.WIDTH(16)) dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .event_pin(event_pin),
    .rtc_in(rtc_in), .debug_break(debug_break), .capture_pin_a(capture_pin_a),
    .capture_pin_b(capture_pin_b), .compare_out(compare_out), .pwm_out(pwm_out), .irq(irq));

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobe stays up on return so a read may follow with no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask

  // Answer is only valid in the cycle after the strobe, so sample mid-cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    cmp8(reg_rdata, exp);
    @(posedge clock);
  endtask

  task automatic idle(input int n);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  // Slow pulses, well under half the clock rate, on the pin of timer 1 or the RTC line
  task automatic pulse(input bit use_rtc, input int n);
    for (int i = 0; i < n; i++) begin
      if (use_rtc) rtc_in <= 1'b1;
      else event_pin[1] <= 1'b1;
      idle(4);
      if (use_rtc) rtc_in <= 1'b0;
      else event_pin[1] <= 1'b0;
      idle(4);
    end
  endtask

  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rd_chk(TBASE[i], 8'h00);
      rd_chk(TBASE[i] + 8'h01, 8'h00);
      rd_chk(TBASE[i] + 8'h02, 8'h00);
    end
    rd_chk(8'h00, 8'h00);
    wr(8'hFF, 8'h5A);
    rd_chk(8'hFF, 8'h00);
    wr(8'h61, 8'hA4);
    rd_chk(8'h61, 8'hA4);
    wr(8'h60, 8'h84);
    rd_chk(8'h60, 8'h84);
    $display("reset test done, mismatches %0d", n_fail);
  endtask

  task automatic t_force;
    wr(8'h63, 8'h34);
    wr(8'h64, 8'h12);
    wr(8'h60, 8'h02);
    rd_chk(8'h63, 8'h34);
    rd_chk(8'h64, 8'h12);
    wr(8'h63, 8'h55);
    wr(8'h60, 8'h00);
    rd_chk(8'h63, 8'h34);
    $display("force reload test done, mismatches %0d", n_fail);
  endtask

  // Every divider code, single pass: ticks at N, 2N, 3N after enable
  task automatic t_prescale;
    int n;
    for (int d = 0; d < 4; d++) begin
      n = 4 << (2 * d);
      wr(8'h63, 8'h03);
      wr(8'h64, 8'h00);
      wr(8'h60, 8'h02);
      wr(8'h60, (8'(d) << 3) | 8'h01);
      idle(n - 1);
      rd_chk(8'h63, 8'h03);
      rd_chk(8'h63, 8'h02);
      idle(2 * n - 3);
      rd_chk(8'h60, 8'(d) << 3);
      rd_chk(8'h63, 8'h00);
      cmp8({7'h00, irq}, 8'h00);
      rd_chk(8'h62, 8'h01);
      rd_chk(8'h62, 8'h00);
    end
    $display("prescale test done, mismatches %0d", n_fail);
  endtask

  // Three edges per case on timer 1 from reload 10
  task automatic ev_case(input logic [7:0] ctl, input bit use_rtc, input logic brk, input logic [7:0] exp);
    debug_break <= brk;
    wr(8'h65, ctl);
    pulse(use_rtc, 3);
    rd_chk(8'h68, exp);
  endtask

  task automatic t_event;
    wr(8'h68, 8'h0A);
    wr(8'h69, 8'h00);
    ev_case(8'h63, 1'b0, 1'b0, 8'h07);
    ev_case(8'h43, 1'b0, 1'b0, 8'h07);
    ev_case(8'h23, 1'b1, 1'b0, 8'h07);
    ev_case(8'hE3, 1'b0, 1'b1, 8'h0A);
    ev_case(8'h63, 1'b0, 1'b1, 8'h07);
    ev_case(8'h62, 1'b0, 1'b0, 8'h0A);
    $display("event test done, mismatches %0d", n_fail);
  endtask

  task automatic t_continuous;
    wr(8'h70, 8'h01);
    wr(8'h72, 8'h02);
    wr(8'h73, 8'h00);
    wr(8'h6F, 8'h02);
    wr(8'h6F, 8'h05);
    idle(9);
    rd_chk(8'h72, 8'h02);
    rd_chk(8'h6F, 8'h05);
    cmp8({7'h00, irq}, 8'h01);
    wr(8'h6F, 8'h00);
    rd_chk(8'h71, 8'h01);
    rd_chk(8'h71, 8'h00);
    cmp8({7'h00, irq}, 8'h00);
    $display("continuous test done, mismatches %0d", n_fail);
  endtask

  // Channel 0 sets its pin when timer 3 passes 0002 on the way down
  task automatic t_compare;
    wr(8'h81, 8'h02);
    wr(8'h80, 8'h01);
    wr(8'h7F, 8'h01);
    wr(8'h75, 8'h08);
    wr(8'h77, 8'h04);
    wr(8'h74, 8'h03);
    idle(8);
    cmp8({3'h0, irq, compare_out}, 8'h00);
    idle(2);
    cmp8({3'h0, irq, compare_out}, 8'h11);
    rd_chk(8'h76, 8'h08);
    idle(8);
    rd_chk(8'h74, 8'h00);
    cmp8({3'h0, irq, compare_out}, 8'h01);
    $display("compare test done, mismatches %0d", n_fail);
  endtask

  // Timer 1 latches its stopped count on pin A, timer 3 its loaded count on pin B
  task automatic t_capture;
    wr(8'h6A, 8'h01);
    wr(8'h7A, 8'h04);
    wr(8'h74, 8'h02);
    capture_pin_a <= 2'h1;
    capture_pin_b <= 2'h2;
    idle(4);
    rd_chk(8'h6B, 8'h0A);
    rd_chk(8'h6C, 8'h00);
    rd_chk(8'h7D, 8'h04);
    rd_chk(8'h7E, 8'h00);
    rd_chk(8'h67, 8'h02);
    $display("capture test done, mismatches %0d", n_fail);
  endtask

  // PWM channel 0 high from count 3 down to count 1; then the overlay by mode
  task automatic t_overlay;
    wr(8'h79, 8'h01);
    wr(8'h7C, 8'h03);
    wr(8'h7E, 8'h01);
    wr(8'h74, 8'h03);
    idle(8);
    cmp8({4'h0, pwm_out}, 8'h01);
    idle(6);
    cmp8({4'h0, pwm_out}, 8'h00);
    wr(8'h79, 8'h00);
    wr(8'h7F, 8'h10);
    wr(8'h79, 8'h01);
    wr(8'h7F, 8'h22);
    rd_chk(8'h7F, 8'h22);
    wr(8'h79, 8'h00);
    rd_chk(8'h7F, 8'h10);
    $display("overlay test done, mismatches %0d", n_fail);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_force();
    t_prescale();
    t_event();
    t_continuous();
    t_compare();
    t_capture();
    t_overlay();
    give_verdict();
  end

  // Guard against a hung run
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule
